/* File: dv/sram_ecc_model.sv */
// Purpose: behavioural ecc static memory
// Assumes: released pins show the inverse of their last value
// Notes: one address may be marked as holding a corrected error
`timescale 1ns/1ns
module sram_ecc_model
    import sram_host_pkg::*;
#(
    parameter int ACCESS_NS = 10
) (
    input wire mem_ctl_t ctl_i,
    input wire logic [31:0] data_i,
    input wire logic [18:0] err_addr_i,
    output logic [31:0] data_o,
    output logic err_o
);
    logic [31:0] mem [logic [18:0]];
    logic sel, wr, rd;
    assign sel = ctl_i.chip_sel_n == 3'h0;
    assign wr = sel && !ctl_i.write_strobe_n;
    assign rd = sel && !ctl_i.out_en_n && ctl_i.write_strobe_n;
    initial begin
        data_o = 32'h0;
        err_o = 1'b0;
    end
    // ========================================
    // write commits at whichever enable rises first
    always @(negedge wr) begin
        for (int i = 0; i < 4; i++)
            if (!ctl_i.byte_en_n[i]) mem[ctl_i.addr][8*i +: 8] = data_i[8*i +: 8];
    end
    // output appears only after the access time; floating lanes toggle
    always @(ctl_i) begin
        #ACCESS_NS;
        for (int i = 0; i < 4; i++)
            data_o[8*i +: 8] = (rd && !ctl_i.byte_en_n[i]) ? mem[ctl_i.addr][8*i +: 8] : ~data_o[8*i +: 8];
        err_o = rd ? ctl_i.addr == err_addr_i : ~err_o;
    end
endmodule

/* File: dv/sram_host_checker.sv */
// Purpose: port checker for the memory host controller
// Assumes: fast grade, read answer four edges after the take
// Notes: bound from the testbench top
`timescale 1ns/1ns
module sram_host_checker
    import sram_host_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire host_req_t req_i,
    input wire logic rsp_valid_o,
    input wire logic init_done_o,
    input wire mem_ctl_t mem_ctl_o,
    input wire logic [31:0] mem_data_o,
    input wire logic [3:0] mem_data_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ========================================
    // pin rules
    property p_idle_pre_init; !init_done_o |-> &mem_ctl_o.chip_sel_n; endproperty
    a_idle_pre_init: assert property (p_idle_pre_init) else $error("access before power-up wait");
    property p_cs_together; mem_ctl_o.chip_sel_n inside {3'h0, 3'h7}; endproperty
    a_cs_together: assert property (p_cs_together) else $error("chip selects split");
    property p_read_strobe; !mem_ctl_o.out_en_n |-> mem_ctl_o.write_strobe_n; endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("strobe low in read");
    property p_no_fight; !mem_ctl_o.out_en_n |-> mem_data_oe_o == 4'h0; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven with outputs on");
    property p_write_sel;
        !mem_ctl_o.write_strobe_n |-> mem_ctl_o.chip_sel_n == 3'h0 && mem_data_oe_o == ~mem_ctl_o.byte_en_n;
    endproperty
    a_write_sel: assert property (p_write_sel) else $error("bad write select or lanes");
    // strobe must end the write while select and data still stand
    property p_write_end; $rose(mem_ctl_o.write_strobe_n) |-> mem_ctl_o.chip_sel_n == 3'h0 &&
        mem_data_oe_o != 4'h0 && $stable(mem_data_o); endproperty
    a_write_end: assert property (p_write_end) else $error("data moved at write end");
    property p_addr_setup; !mem_ctl_o.write_strobe_n |-> $stable(mem_ctl_o.addr) && $stable(mem_ctl_o.byte_en_n);
    endproperty
    a_addr_setup: assert property (p_addr_setup) else $error("address moved in write");
    property p_read_pins; req_valid_i && req_ready_o && !req_i.write |=> mem_ctl_o.chip_sel_n == 3'h0 &&
        !mem_ctl_o.out_en_n && mem_ctl_o.byte_en_n == 4'h0 && mem_ctl_o.addr == $past(req_i.addr); endproperty
    a_read_pins: assert property (p_read_pins) else $error("read pins wrong");
    property p_read_lat; req_valid_i && req_ready_o && !req_i.write |=> !rsp_valid_o [*3] ##1 rsp_valid_o;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer not on fourth edge");
endmodule

/* File: dv/test_sram_host_ctrl.sv */
// Purpose: directed testbench for the memory host controller
// Assumes: fast grade, power-up wait shortened to 8 clocks
// Notes: model stands in for the memory
`timescale 1ns/1ns
module test_sram_host_ctrl;
    import sram_host_pkg::*;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_valid_i = 1'b0;
    host_req_t req_i = '0;
    logic [18:0] err_addr = 19'h00001;
    logic req_ready_o, rsp_valid_o, rsp_err_o, init_done_o, mem_err_i;
    logic [31:0] rsp_rdata_o, mem_data_o, mem_bus, model_data;
    logic [3:0] mem_data_oe_o;
    mem_ctl_t mem_ctl_o;
    int errors = 0;
    int checks = 0;
    always #20 core_clk_i = ~core_clk_i;
    always_comb for (int i = 0; i < 4; i++)
        mem_bus[8*i +: 8] = mem_data_oe_o[i] ? mem_data_o[8*i +: 8] : model_data[8*i +: 8];
    sram_host_ctrl #(.POWER_UP_CYCLES(8)) u_sram_host_ctrl (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .rsp_err_o(rsp_err_o), .init_done_o(init_done_o), .mem_ctl_o(mem_ctl_o),
        .mem_data_i(mem_bus), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o), .mem_err_i(mem_err_i));
    sram_ecc_model u_sram_ecc_model (.ctl_i(mem_ctl_o), .data_i(mem_bus), .err_addr_i(err_addr),
        .data_o(model_data), .err_o(mem_err_i));
    // ========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic access(input logic wr, input logic [18:0] a, input logic [3:0] be, input logic [31:0] d,
        output logic [31:0] q, output logic e, output int lat);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 50) @(posedge core_clk_i) #1 n++;
        req_i = '{wr, a, be, d};
        req_valid_i = 1'b1;
        @(posedge core_clk_i) #1 req_valid_i = 1'b0;
        lat = 0;
        while (!wr && rsp_valid_o !== 1'b1 && lat < 50) @(posedge core_clk_i) #1 lat++;
        q = rsp_rdata_o;
        e = rsp_err_o;
        if (n == 50 || lat == 50) begin
            errors++;
            final_report();
        end
    endtask
    task automatic rd_check(input logic [18:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        int lat;
        access(1'b0, a, 4'hf, 32'h0, q, e, lat);
        check(q, exp);
        check({31'h0, e}, {31'h0, exp_err});
        check(lat, 3);
    endtask
    // ========================================
    // scenarios
    task automatic t_power_up;
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 50) begin
            check({29'h0, mem_ctl_o.chip_sel_n}, 32'h7);
            @(posedge core_clk_i) #1 n++;
        end
        check(32'(n >= 8), 32'h1);
        $display("test power_up done");
    endtask
    task automatic t_lanes;
        logic [31:0] q, exp, d;
        logic e;
        int lat;
        exp = 32'h0;
        access(1'b1, 19'h10, 4'hf, 32'h12345678, q, e, lat);
        rd_check(19'h10, 32'h12345678, 1'b0);
        access(1'b1, 19'h7ffff, 4'hf, exp, q, e, lat);
        for (int i = 0; i < 4; i++) begin
            d = 32'h8899aabb ^ (32'h0f0f0f0f << i);
            access(1'b1, 19'h7ffff, 4'(1 << i), d, q, e, lat);
            exp[8*i +: 8] = d[8*i +: 8];
            rd_check(19'h7ffff, exp, 1'b0);
        end
        $display("test lanes done");
    endtask
    task automatic t_error;
        err_addr = 19'h10;
        rd_check(19'h10, 32'h12345678, 1'b1);
        rd_check(19'h7ffff, 32'hf0a5b4b4, 1'b0);
        $display("test error done");
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        t_power_up();
        t_lanes();
        t_error();
        final_report();
    end
endmodule
bind sram_host_ctrl sram_host_checker u_sram_host_checker (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
    .init_done_o(init_done_o), .mem_ctl_o(mem_ctl_o), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));

/* File: logic/sram_host_cfg.svh */
// Purpose: timing and width constants for the static memory host controller
// Assumes: core clock of 25 MHz
// Notes: times in picoseconds except the power-up wait in microseconds, counts derived by ceiling
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
`define CLK_PERIOD_PS 40000
`define POWER_UP_WAIT_TIME_US 100
`define ADDRESS_ACCESS_TIME_FAST_PS 10000
`define ADDRESS_ACCESS_TIME_SLOW_PS 15000
`define WRITE_TURNOFF_DELAY_FAST_PS 5000
`define WRITE_TURNOFF_DELAY_SLOW_PS 8000
`define WRITE_DATA_SETUP_TIME_FAST_PS 5000
`define WRITE_DATA_SETUP_TIME_SLOW_PS 8000
`define ADDR_SETUP_WRITE_END_FAST_PS 7000
`define ADDR_SETUP_WRITE_END_SLOW_PS 12000
`define CEIL_CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define POWER_UP_CYCLES ((`POWER_UP_WAIT_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ADDR_W 19
`define DATA_W 32
`define LANES 4
`endif

/* File: logic/sram_host_ctrl.sv */
// Purpose: host-side controller driving an asynchronous ecc static memory
// Assumes: one 25 MHz clock, synchronous active-high reset at power-good
// Notes: each access is whole clock periods, so every minimum rounds up
`timescale 1ns/1ns
// What this block does
// - select memory only by driving all three chip selects low together
// - begin writes with write strobe and chip select both low
// - end write by raising write strobe first, chip select after
// - data setup and hold counted against the write strobe rising edge
// - strobe low time covers turn-off delay plus data setup
// - keep data drivers off while memory may still drive the bus
// - wait 100 us after reset before the first access
// - sample read data and error no earlier than access time
// - write strobe held high through every read
// - address is valid before or with chip select going low
// - address-driven reads allowed with enables held asserted; not used here, every read ends by raising chip selects and output enable
// - address held valid at least setup time before write end
// - byte enables asserted at least setup time before write end
// - byte enable n selects data byte lane n, lowest first
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter bit SLOW_GRADE = 1'b0,
    parameter int POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire host_req_t req_i,
    output logic rsp_valid_o,
    output logic [`DATA_W-1:0] rsp_rdata_o,
    output logic rsp_err_o,
    output logic init_done_o,
    output mem_ctl_t mem_ctl_o,
    input wire logic [`DATA_W-1:0] mem_data_i,
    output logic [`DATA_W-1:0] mem_data_o,
    output logic [`LANES-1:0] mem_data_oe_o,
    input wire logic mem_err_i
);
    // ====================================================================
    // timing counts
    localparam int ACC_PS = SLOW_GRADE ? `ADDRESS_ACCESS_TIME_SLOW_PS : `ADDRESS_ACCESS_TIME_FAST_PS;
    localparam int HZ_PS = SLOW_GRADE ? `WRITE_TURNOFF_DELAY_SLOW_PS : `WRITE_TURNOFF_DELAY_FAST_PS;
    localparam int SD_PS = SLOW_GRADE ? `WRITE_DATA_SETUP_TIME_SLOW_PS : `WRITE_DATA_SETUP_TIME_FAST_PS;
    localparam int AW_PS = SLOW_GRADE ? `ADDR_SETUP_WRITE_END_SLOW_PS : `ADDR_SETUP_WRITE_END_FAST_PS;
    // two sync stages add latency, so one clock of access covers the input path too
    localparam int ACC_CYC = `CEIL_CYC(ACC_PS) < 1 ? 1 : `CEIL_CYC(ACC_PS);
    localparam int PW_RAW = `CEIL_CYC(HZ_PS + SD_PS) > `CEIL_CYC(AW_PS) ?
                            `CEIL_CYC(HZ_PS + SD_PS) : `CEIL_CYC(AW_PS);
    localparam int PW_CYC = PW_RAW < 1 ? 1 : PW_RAW;
    localparam int GAP_CYC = `CEIL_CYC(HZ_PS) < 1 ? 1 : `CEIL_CYC(HZ_PS);
    localparam int CW = 24;

    initial begin
        if (POWER_UP_CYCLES < 1 || POWER_UP_CYCLES >= (1 << CW)) begin
            $error("POWER_UP_CYCLES out of range");
        end
    end

    // ====================================================================
    // input synchronisers
    logic [`DATA_W-1:0] rd_meta, rd_sync;
    logic err_meta, err_sync;
    always_ff @(posedge core_clk_i) begin
        rd_meta <= mem_data_i;
        rd_sync <= rd_meta;
        err_meta <= mem_err_i;
        err_sync <= err_meta;
    end

    // ====================================================================
    // sequencer
    host_state_t state;
    logic [CW-1:0] cnt;
    host_req_t cur;

    assign req_ready_o = (state == st_idle);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= st_power_up;
            cnt <= CW'(POWER_UP_CYCLES);
            cur <= '0;
        end else begin
            case (state)
                st_power_up: begin
                    if (cnt == CW'(1)) begin
                        state <= st_idle;
                    end
                    cnt <= cnt - CW'(1);
                end
                st_idle: begin
                    if (req_valid_i) begin
                        cur <= req_i;
                        if (req_i.write) begin
                            state <= st_write_gap;
                            cnt <= CW'(GAP_CYC);
                        end else begin
                            state <= st_read;
                            // two sync stages plus access time
                            cnt <= CW'(ACC_CYC + 2);
                        end
                    end
                end
                st_read: begin
                    if (cnt == CW'(1)) begin
                        state <= st_idle;
                    end
                    cnt <= cnt - CW'(1);
                end
                st_write_gap: begin
                    if (cnt == CW'(1)) begin
                        state <= st_write;
                        cnt <= CW'(PW_CYC);
                    end else begin
                        cnt <= cnt - CW'(1);
                    end
                end
                st_write: begin
                    if (cnt == CW'(1)) begin
                        state <= st_write_end;
                    end
                    cnt <= cnt - CW'(1);
                end
                st_write_end: begin
                    state <= st_idle;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // ====================================================================
    // pin drive
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mem_ctl_o.chip_sel_n <= 3'h7;
            mem_ctl_o.write_strobe_n <= 1'b1;
            mem_ctl_o.out_en_n <= 1'b1;
            mem_ctl_o.byte_en_n <= {`LANES{1'b1}};
            mem_ctl_o.addr <= '0;
            mem_data_o <= '0;
            mem_data_oe_o <= '0;
        end else begin
            mem_ctl_o.write_strobe_n <= 1'b1;
            mem_data_oe_o <= '0;
            if (state == st_idle && req_valid_i) begin
                // address settles with chip select, never after it
                mem_ctl_o.addr <= req_i.addr;
                mem_ctl_o.chip_sel_n <= 3'h0;
                mem_ctl_o.byte_en_n <= req_i.write ? ~req_i.byte_en : {`LANES{1'b0}};
                mem_ctl_o.out_en_n <= req_i.write;
                mem_data_o <= req_i.wdata;
            end else if (state == st_write_gap && cnt == CW'(1)) begin
                mem_ctl_o.write_strobe_n <= 1'b0;
                mem_data_oe_o <= cur.byte_en;
            end else if (state == st_write && cnt != CW'(1)) begin
                mem_ctl_o.write_strobe_n <= 1'b0;
                mem_data_oe_o <= cur.byte_en;
            end else if (state == st_write && cnt == CW'(1)) begin
                // strobe rises first and ends the write; data held one more clock
                mem_ctl_o.write_strobe_n <= 1'b1;
                mem_data_oe_o <= cur.byte_en;
            end else if (state == st_write_end || (state == st_read && cnt == CW'(1))) begin
                mem_ctl_o.chip_sel_n <= 3'h7;
                mem_ctl_o.out_en_n <= 1'b1;
                mem_ctl_o.byte_en_n <= {`LANES{1'b1}};
            end
        end
    end

    // ====================================================================
    // read capture and status
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
            rsp_err_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (state == st_read && cnt == CW'(1)) begin
                rsp_valid_o <= 1'b1;
                rsp_rdata_o <= rd_sync;
                rsp_err_o <= err_sync;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            init_done_o <= 1'b0;
        end else begin
            init_done_o <= (state != st_power_up);
        end
    end
endmodule

/* File: logic/sram_host_pkg.sv */
// Purpose: types for the static memory host controller
// Assumes: sram_host_cfg.svh supplies widths
// Notes: pin bundle carries every memory control and address line; data and error lines are separate ports
`include "sram_host_cfg.svh"
package sram_host_pkg;
    typedef struct packed {
        logic [2:0] chip_sel_n;
        logic write_strobe_n;
        logic out_en_n;
        logic [`LANES-1:0] byte_en_n;
        logic [`ADDR_W-1:0] addr;
    } mem_ctl_t;
    typedef struct packed {
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`LANES-1:0] byte_en;
        logic [`DATA_W-1:0] wdata;
    } host_req_t;
    typedef enum logic [2:0] {
        st_power_up, st_idle, st_read, st_write_gap, st_write, st_write_end
    } host_state_t;
endpackage
